// file: relay_matrix_pkg.sv
// Shared constants of the relay control-signal matrix: register map,
// switch bit positions, reset values and display scaling.
// Assumes a 32-bit AHB-Lite register bus and one 100 MHz clock.
`default_nettype none

package relay_matrix_pkg;
    // ==========================================================
    // Structure
    localparam int NUM_CTRL_GROUPS  = 3;
    localparam int NUM_ROUTE_GROUPS = 11;
    localparam int GROUP_W          = 8;
    localparam int NUM_STAGES       = 5;
    localparam int NUM_OUT          = 4;
    localparam int VAL_W            = 10;
    localparam int NUM_EVENTS       = 4;
    localparam int NUM_LAMPS        = 4;
    localparam int CSUM_SEL_W       = 4;

    // ==========================================================
    // Switch bit positions inside a control-input switchgroup
    localparam int SW_BLOCK_LAST = 3;
    localparam int SW_BANK       = 4;
    localparam int SW_AUX        = 5;
    localparam int SW_RST_LATCH  = 6;
    localparam int SW_RST_REG    = 7;
    localparam int IMB_STAGE     = 4;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_CTRL_GRP  = 8'h04;
    localparam logic [7:0] OFS_ROUTE_GRP = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h3c;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h40;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h44;
    localparam logic [7:0] OFS_DISP_SEL  = 8'h48;
    localparam logic [7:0] OFS_DISP_VAL  = 8'h4c;
    localparam logic [7:0] OFS_CSUM_SEL  = 8'h50;
    localparam logic [7:0] OFS_CSUM      = 8'h54;

    localparam logic [GROUP_W-1:0] RST_GROUP = 8'h00;
    localparam logic [31:0]        RD_ZERO   = 32'h0000_0000;

    // Interrupt event bits
    localparam int EV_BANK  = 0;
    localparam int EV_RESET = 1;
    localparam int EV_TRIP  = 2;
    localparam int EV_BLOCK = 3;

    // ==========================================================
    // Display: currents in tenths of rated current, imbalance in percent
    typedef enum logic [2:0] {
        DISP_L1, DISP_L2, DISP_L3, DISP_RESID, DISP_IMBAL
    } disp_sel_t;
    localparam logic [VAL_W-1:0] PHASE_MAX = 10'h276;
    localparam logic [VAL_W-1:0] RESID_MAX = 10'h0d2;
    localparam logic [6:0]       PCT_FULL  = 7'h64;
endpackage

`default_nettype wire

// file: switch_checksum.sv
// Registered checksum of one switchgroup: sum of the weights of set bits.
// Assumes the switch value is stable for a cycle before it is read.
`timescale 1ns/1ns
`default_nettype none

module switch_checksum #(
    parameter int W = 8
) (
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic [W-1:0] sw_in,
    output logic      [W-1:0] sum_out
);
    logic [W-1:0] part [W+1];

    assign part[0] = '0;
    // Bit i weighs 2**i, i.e. switch i+1
    for (genvar i = 0; i < W; i++) begin : g_wt
        assign part[i+1] = part[i] + (sw_in[i] ? W'(1 << i) : W'(0));
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sum_out <= '0;
        end else begin
            sum_out <= part[W];
        end
    end
endmodule

`default_nettype wire

// file: measure_display.sv
// Picks and scales the measured value for the three display digits and
// drives one lamp naming the shown quantity (the residual lamp for imbalance). Inputs come from the
// measuring logic on the same clock, in tenths of rated current.
`timescale 1ns/1ns
`default_nettype none

module measure_display
    import relay_matrix_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 rst_b_in,
    input  wire disp_sel_t            sel_in,
    input  wire logic [VAL_W-1:0]     phase_l1_in,
    input  wire logic [VAL_W-1:0]     phase_l2_in,
    input  wire logic [VAL_W-1:0]     phase_l3_in,
    input  wire logic [VAL_W-1:0]     resid_in,
    output logic      [VAL_W-1:0]     value_out,
    output logic      [NUM_LAMPS-1:0] lamp_out
);
    logic [VAL_W-1:0] l1_c, l2_c, l3_c, r_c, mx, mn, pct, val_nxt;
    logic [VAL_W+6:0] diff_scaled;
    logic [NUM_LAMPS-1:0] lamp_nxt;

    assign l1_c = (phase_l1_in > PHASE_MAX) ? PHASE_MAX : phase_l1_in;
    assign l2_c = (phase_l2_in > PHASE_MAX) ? PHASE_MAX : phase_l2_in;
    assign l3_c = (phase_l3_in > PHASE_MAX) ? PHASE_MAX : phase_l3_in;
    assign r_c  = (resid_in > RESID_MAX) ? RESID_MAX : resid_in;
    assign mx = (l1_c >= l2_c && l1_c >= l3_c) ? l1_c : ((l2_c >= l3_c) ? l2_c : l3_c);
    assign mn = (l1_c <= l2_c && l1_c <= l3_c) ? l1_c : ((l2_c <= l3_c) ? l2_c : l3_c);
    assign diff_scaled = (VAL_W+7)'(mx - mn) * (VAL_W+7)'(PCT_FULL);
    // Spread relative to the largest phase; no current shows 0 %
    assign pct = (mx == '0) ? '0 : VAL_W'(diff_scaled / (VAL_W+7)'(mx));

    assign val_nxt = (sel_in == DISP_L1) ? l1_c :
                     (sel_in == DISP_L2) ? l2_c :
                     (sel_in == DISP_L3) ? l3_c :
                     (sel_in == DISP_IMBAL) ? pct : r_c;
    // The imbalance submenu keeps the residual lamp lit
    assign lamp_nxt = (sel_in == DISP_L1) ? 4'h1 :
                      (sel_in == DISP_L2) ? 4'h2 :
                      (sel_in == DISP_L3) ? 4'h4 : 4'h8;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            value_out <= '0;
            lamp_out  <= '0;
        end else begin
            value_out <= val_nxt;
            lamp_out  <= lamp_nxt;
        end
    end
endmodule

`default_nettype wire

// file: relay_control_signal_matrix.sv
// Control-signal and output-routing matrix of a protection relay module,
// with AHB-Lite register access, checksums, display and interrupt.
// Assumes field control inputs are asynchronous and stage signals are
// on clk_in; the master issues single word transfers only.
// Contract
// - Blocking switch bit set inhibits its stage while its control input is high.
// - Settings bank switches by serial command or by an external control input.
// - Bank routing bit 0 makes the control input unable to change the bank.
// - Bank routing bit 1 takes the bank solely from the control input level.
// - Bit 6 of group one blocks the imbalance stage while input one is high.
// - Bit 6 of groups two and three lets the input clear the indicators.
// - Bit 7 lets the input clear indicators and latched output relays.
// - Bit 8 lets the input clear indicators, latched relays and recorded registers.
// - Eleven routing groups map stage signals onto four start and four trip outputs.
// - Checksum equals the sum of binary weights of all set switch bits.
// - Display shows the chosen measured value and lights one identifying lamp.
// - Phase currents shown as multiples of rated current, zero to 63.
// - Residual current shown as multiples of rated current, zero to 21.
// - Imbalance submenu shows phase spread as a percentage, zero to 100.
// - Third control input also serves as the remote reset input.
`timescale 1ns/1ns
`default_nettype none

module relay_control_signal_matrix
    import relay_matrix_pkg::*;
(
    input  wire logic                                   clk_in,
    input  wire logic                                   rst_b_in,
    input  wire logic                                   hsel_in,
    input  wire logic [31:0]                            haddr_in,
    input  wire logic [1:0]                             htrans_in,
    input  wire logic                                   hwrite_in,
    input  wire logic [2:0]                             hsize_in,
    input  wire logic                                   hready_in,
    input  wire logic [31:0]                            hwdata_in,
    output logic      [31:0]                            hrdata_out,
    output logic                                        hreadyout_out,
    output logic                                        hresp_out,
    input  wire logic                                   block_input_one_in,
    input  wire logic                                   block_input_two_in,
    input  wire logic                                   block_input_three_in,
    input  wire logic [relay_matrix_pkg::NUM_ROUTE_GROUPS-1:0] route_src_in,
    input  wire logic [relay_matrix_pkg::VAL_W-1:0]     phase_l1_in,
    input  wire logic [relay_matrix_pkg::VAL_W-1:0]     phase_l2_in,
    input  wire logic [relay_matrix_pkg::VAL_W-1:0]     phase_l3_in,
    input  wire logic [relay_matrix_pkg::VAL_W-1:0]     residual_current_in,
    output logic      [relay_matrix_pkg::NUM_STAGES-1:0] stage_block_out,
    output logic      [relay_matrix_pkg::NUM_OUT-1:0]   start_output_out,
    output logic      [relay_matrix_pkg::NUM_OUT-1:0]   trip_output_out,
    output logic                                        active_bank_out,
    output logic                                        reset_indicators_out,
    output logic                                        reset_latches_out,
    output logic                                        reset_registers_out,
    output logic      [relay_matrix_pkg::VAL_W-1:0]     disp_value_out,
    output logic      [relay_matrix_pkg::NUM_LAMPS-1:0] disp_lamp_out,
    output logic                                        irq_out
);
    // ==========================================================
    // Control input synchronisers
    logic [NUM_CTRL_GROUPS-1:0] ctrl_meta_r;
    logic [NUM_CTRL_GROUPS-1:0] ctrl_sync_r;
    logic [NUM_CTRL_GROUPS-1:0] ctrl_pin;

    // Third input doubles as the remote reset input
    assign ctrl_pin = {block_input_three_in, block_input_two_in, block_input_one_in};

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_meta_r <= '0;
            ctrl_sync_r <= '0;
        end else begin
            ctrl_meta_r <= ctrl_pin;
            ctrl_sync_r <= ctrl_meta_r;
        end
    end

    // ==========================================================
    // AHB-Lite slave, zero wait states
    logic       ahb_take;
    logic       wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [7:0] a_ofs;
    logic [31:0] rd_nxt;
    logic       serial_bank_r;
    disp_sel_t  disp_sel_r;
    logic [CSUM_SEL_W-1:0] csum_sel_r;
    logic [NUM_EVENTS-1:0] irq_stat_r;
    logic [NUM_EVENTS-1:0] irq_mask_r;

    assign ahb_take      = hsel_in && htrans_in[1] && hready_in;
    assign a_ofs         = haddr_in[7:0];
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_pend_r  <= 1'b0;
            wr_addr_r  <= '0;
            hrdata_out <= RD_ZERO;
        end else begin
            wr_pend_r  <= ahb_take && hwrite_in;
            wr_addr_r  <= a_ofs;
            hrdata_out <= (ahb_take && !hwrite_in) ? rd_nxt : hrdata_out;
        end
    end

    // Write strobes decoded from the held data-phase address
    logic wr_ctrl, wr_irq_stat, wr_irq_mask, wr_disp_sel, wr_csum_sel;
    assign wr_ctrl     = wr_pend_r && (wr_addr_r == OFS_CTRL);
    assign wr_irq_stat = wr_pend_r && (wr_addr_r == OFS_IRQ_STAT);
    assign wr_irq_mask = wr_pend_r && (wr_addr_r == OFS_IRQ_MASK);
    assign wr_disp_sel = wr_pend_r && (wr_addr_r == OFS_DISP_SEL);
    assign wr_csum_sel = wr_pend_r && (wr_addr_r == OFS_CSUM_SEL);

    // ==========================================================
    // Switchgroup storage
    logic [GROUP_W-1:0] ctrl_grp_r  [NUM_CTRL_GROUPS];
    logic [GROUP_W-1:0] route_grp_r [NUM_ROUTE_GROUPS];

    for (genvar g = 0; g < NUM_CTRL_GROUPS; g++) begin : g_ctrl_reg
        logic wr_hit;
        assign wr_hit = wr_pend_r && (wr_addr_r == OFS_CTRL_GRP + 8'(4 * g));
        always_ff @(posedge clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                ctrl_grp_r[g] <= RST_GROUP;
            end else if (wr_hit) begin
                ctrl_grp_r[g] <= hwdata_in[GROUP_W-1:0];
            end
        end
    end

    for (genvar g = 0; g < NUM_ROUTE_GROUPS; g++) begin : g_route_reg
        logic wr_hit;
        assign wr_hit = wr_pend_r && (wr_addr_r == OFS_ROUTE_GRP + 8'(4 * g));
        always_ff @(posedge clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                route_grp_r[g] <= RST_GROUP;
            end else if (wr_hit) begin
                route_grp_r[g] <= hwdata_in[GROUP_W-1:0];
            end
        end
    end

    // ==========================================================
    // Control-input functions per group
    logic [NUM_STAGES-1:0]      grp_blk [NUM_CTRL_GROUPS];
    logic [NUM_CTRL_GROUPS-1:0] bank_route, rst_ind_g, rst_lat_g, rst_reg_g;

    for (genvar g = 0; g < NUM_CTRL_GROUPS; g++) begin : g_ctrl_fn
        logic in_hi;
        assign in_hi = ctrl_sync_r[g];
        assign grp_blk[g][SW_BLOCK_LAST:0] =
            {(SW_BLOCK_LAST + 1){in_hi}} & ctrl_grp_r[g][SW_BLOCK_LAST:0];
        // Only group one's aux bit blocks the imbalance stage
        assign grp_blk[g][IMB_STAGE] = (g == 0) && in_hi && ctrl_grp_r[g][SW_AUX];
        assign bank_route[g] = ctrl_grp_r[g][SW_BANK];
        assign rst_ind_g[g]  = in_hi && (((g != 0) && ctrl_grp_r[g][SW_AUX])
                               || ctrl_grp_r[g][SW_RST_LATCH] || ctrl_grp_r[g][SW_RST_REG]);
        assign rst_lat_g[g]  = in_hi && (ctrl_grp_r[g][SW_RST_LATCH] || ctrl_grp_r[g][SW_RST_REG]);
        assign rst_reg_g[g]  = in_hi && ctrl_grp_r[g][SW_RST_REG];
    end

    logic [NUM_STAGES-1:0] blk_nxt;
    logic bank_nxt, bank_ext, bank_routed;
    assign blk_nxt     = grp_blk[0] | grp_blk[1] | grp_blk[2];
    assign bank_routed = |bank_route;
    assign bank_ext    = |(bank_route & ctrl_sync_r);
    // Routed input overrides the serial command entirely
    assign bank_nxt    = bank_routed ? bank_ext : serial_bank_r;

    // ==========================================================
    // Output routing matrix
    logic [GROUP_W-1:0] route_acc [NUM_ROUTE_GROUPS+1];
    assign route_acc[0] = '0;
    for (genvar g = 0; g < NUM_ROUTE_GROUPS; g++) begin : g_route
        assign route_acc[g+1] = route_acc[g] | ({GROUP_W{route_src_in[g]}} & route_grp_r[g]);
    end

    // ==========================================================
    // Registered outputs and events
    logic [NUM_EVENTS-1:0] ev;
    logic rst_any_nxt, rst_any_r;
    assign rst_any_nxt = |rst_ind_g;
    assign ev[EV_BANK]  = bank_nxt != active_bank_out;
    assign ev[EV_RESET] = rst_any_nxt && !rst_any_r;
    assign ev[EV_TRIP]  = |(route_acc[NUM_ROUTE_GROUPS][GROUP_W-1:NUM_OUT] & ~trip_output_out);
    assign ev[EV_BLOCK] = |(blk_nxt & ~stage_block_out);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stage_block_out      <= '0;
            start_output_out     <= '0;
            trip_output_out      <= '0;
            active_bank_out      <= 1'b0;
            reset_indicators_out <= 1'b0;
            reset_latches_out    <= 1'b0;
            reset_registers_out  <= 1'b0;
            rst_any_r            <= 1'b0;
        end else begin
            stage_block_out      <= blk_nxt;
            start_output_out     <= route_acc[NUM_ROUTE_GROUPS][NUM_OUT-1:0];
            trip_output_out      <= route_acc[NUM_ROUTE_GROUPS][GROUP_W-1:NUM_OUT];
            active_bank_out      <= bank_nxt;
            reset_indicators_out <= rst_any_nxt;
            reset_latches_out    <= |rst_lat_g;
            reset_registers_out  <= |rst_reg_g;
            rst_any_r            <= rst_any_nxt;
        end
    end

    // Software-owned settings; status bits: set wins over clear
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            serial_bank_r <= 1'b0;
            disp_sel_r    <= DISP_L1;
            csum_sel_r    <= '0;
            irq_mask_r    <= '0;
            irq_stat_r    <= '0;
        end else begin
            if (wr_ctrl) serial_bank_r <= hwdata_in[0];
            if (wr_disp_sel) disp_sel_r <= disp_sel_t'(hwdata_in[2:0]);
            if (wr_csum_sel) csum_sel_r <= hwdata_in[CSUM_SEL_W-1:0];
            if (wr_irq_mask) irq_mask_r <= hwdata_in[NUM_EVENTS-1:0];
            irq_stat_r <= ev | (irq_stat_r & ~(wr_irq_stat ? hwdata_in[NUM_EVENTS-1:0] : '0));
        end
    end

    assign irq_out = |(irq_stat_r & irq_mask_r);

    // ==========================================================
    // Checksum and display
    logic [GROUP_W-1:0] csum_src, csum_val;
    assign csum_src = (csum_sel_r < CSUM_SEL_W'(NUM_CTRL_GROUPS)) ? ctrl_grp_r[csum_sel_r[1:0]] :
                      (csum_sel_r < CSUM_SEL_W'(NUM_CTRL_GROUPS + NUM_ROUTE_GROUPS)) ?
                      route_grp_r[csum_sel_r - CSUM_SEL_W'(NUM_CTRL_GROUPS)] : RST_GROUP;

    switch_checksum #(.W(GROUP_W)) u_csum (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .sw_in    (csum_src),
        .sum_out  (csum_val)
    );

    measure_display u_disp (
        .clk_in      (clk_in),
        .rst_b_in    (rst_b_in),
        .sel_in      (disp_sel_r),
        .phase_l1_in (phase_l1_in),
        .phase_l2_in (phase_l2_in),
        .phase_l3_in (phase_l3_in),
        .resid_in    (residual_current_in),
        .value_out   (disp_value_out),
        .lamp_out    (disp_lamp_out)
    );

    // ==========================================================
    // Read mux on the address-phase offset; unmapped reads return zero
    logic [3:0] rd_idx_c, rd_idx_r;
    assign rd_idx_c = 4'((a_ofs - OFS_CTRL_GRP) >> 2);
    assign rd_idx_r = 4'((a_ofs - OFS_ROUTE_GRP) >> 2);

    always_comb begin
        rd_nxt = RD_ZERO;
        if (a_ofs == OFS_CTRL) begin
            rd_nxt[0] = serial_bank_r;
        end else if (a_ofs >= OFS_CTRL_GRP && a_ofs < OFS_ROUTE_GRP && a_ofs[1:0] == 2'b00) begin
            rd_nxt[GROUP_W-1:0] = ctrl_grp_r[rd_idx_c[1:0]];
        end else if (a_ofs >= OFS_ROUTE_GRP && a_ofs < OFS_STATUS && a_ofs[1:0] == 2'b00) begin
            rd_nxt[GROUP_W-1:0] = route_grp_r[rd_idx_r];
        end else if (a_ofs == OFS_STATUS) begin
            rd_nxt[19:0] = {ctrl_sync_r, reset_registers_out, reset_latches_out,
                            reset_indicators_out, active_bank_out, stage_block_out,
                            trip_output_out, start_output_out};
        end else if (a_ofs == OFS_IRQ_STAT) begin
            rd_nxt[NUM_EVENTS-1:0] = irq_stat_r;
        end else if (a_ofs == OFS_IRQ_MASK) begin
            rd_nxt[NUM_EVENTS-1:0] = irq_mask_r;
        end else if (a_ofs == OFS_DISP_SEL) begin
            rd_nxt[2:0] = disp_sel_r;
        end else if (a_ofs == OFS_DISP_VAL) begin
            rd_nxt[VAL_W+NUM_LAMPS-1:0] = {disp_lamp_out, disp_value_out};
        end else if (a_ofs == OFS_CSUM_SEL) begin
            rd_nxt[CSUM_SEL_W-1:0] = csum_sel_r;
        end else if (a_ofs == OFS_CSUM) begin
            rd_nxt[GROUP_W-1:0] = csum_val;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    chk_stage_block:
        assert property (ctrl_sync_r[1] && ctrl_grp_r[1][0] |=> stage_block_out[0])
        else $error("stage not blocked by control input");
    chk_bank_ignored:
        assert property (!bank_routed |=> active_bank_out == $past(serial_bank_r))
        else $error("bank changed by unrouted input");
    chk_bank_routed:
        assert property (bank_route[0] && !bank_route[1] && !bank_route[2]
                         |=> active_bank_out == $past(ctrl_sync_r[0]))
        else $error("bank not taken from input level");
    chk_serial_bank:
        assert property (wr_ctrl && !bank_routed ##1 !bank_routed |=> active_bank_out == $past(hwdata_in[0], 2))
        else $error("serial bank command lost");
    chk_imbal_block:
        assert property (stage_block_out[IMB_STAGE] |-> $past(ctrl_sync_r[0] && ctrl_grp_r[0][SW_AUX]))
        else $error("imbalance block without cause");
    chk_reset_level:
        assert property (reset_registers_out |-> reset_latches_out && reset_indicators_out)
        else $error("register reset without wider reset");
    chk_latch_reset:
        assert property (ctrl_sync_r[2] && ctrl_grp_r[2][SW_RST_LATCH] |=> reset_latches_out && reset_indicators_out)
        else $error("latch reset missing");
    chk_ind_reset:
        assert property (ctrl_sync_r[1] && ctrl_grp_r[1][SW_AUX] |=> reset_indicators_out)
        else $error("indicator reset missing");
    chk_route_trip:
        assert property (route_src_in[0] && route_grp_r[0][NUM_OUT] |=> trip_output_out[0])
        else $error("trip routing missing");
    chk_csum_value:
        assert property ($stable(csum_src) |=> csum_val == $past(csum_src))
        else $error("checksum differs from switch value");
    chk_one_lamp:
        assert property ($past(rst_b_in) |-> $onehot(disp_lamp_out))
        else $error("lamp not one-hot");
    chk_disp_range:
        assert property (disp_lamp_out != 4'h8 |-> disp_value_out <= PHASE_MAX)
        else $error("phase value over range");
endmodule

`default_nettype wire

// file: field_wiring_model.sv
// Field wiring model: drives the three control input pins.
// Assumes the bench asks for pin levels on clk_in.
`timescale 1ns/1ns
`default_nettype none
module field_wiring_model (
    input  wire logic       clk_in,
    input  wire logic [2:0] level_in,
    output logic      [2:0] pin_out
);
    // Contacts move just after an edge, never mid-cycle
    always @(posedge clk_in) pin_out <= level_in;
endmodule
`default_nettype wire

// file: test_relay_control_signal_matrix.sv
// Self-checking bench for the relay control-signal matrix.
// Assumes the package and the field wiring model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_relay_control_signal_matrix;
    import relay_matrix_pkg::*;
    logic                  clk_in = 0, rst_b_in = 0, hsel_in = 1, hwrite_in = 0, hready_in, hreadyout_out, hresp_out;
    logic [31:0]           haddr_in = 0, hwdata_in = 0, hrdata_out, q;
    logic [1:0]            htrans_in = 0;
    logic [2:0]            hsize_in = 3'h2, lvl = 0, pins;
    logic [10:0]           route_src_in = 0;
    logic [VAL_W-1:0]      phase_l1_in = 0, phase_l2_in = 0, phase_l3_in = 0, residual_current_in = 0, disp_value_out;
    logic [NUM_STAGES-1:0] stage_block_out;
    logic [NUM_OUT-1:0]    start_output_out, trip_output_out;
    logic [NUM_LAMPS-1:0]  disp_lamp_out;
    logic                  active_bank_out, reset_indicators_out, reset_latches_out, reset_registers_out, irq_out;
    logic [7:0]            v;
    int                    seed = 32'h690c, n_fail = 0, compares = 0;
    assign hready_in = hreadyout_out;
    field_wiring_model field_wiring_model_inst (.clk_in, .level_in(lvl), .pin_out(pins));
    relay_control_signal_matrix relay_control_signal_matrix_inst (.clk_in, .rst_b_in, .hsel_in, .haddr_in,
        .htrans_in, .hwrite_in, .hsize_in, .hready_in, .hwdata_in, .hrdata_out, .hreadyout_out, .hresp_out,
        .block_input_one_in(pins[0]), .block_input_two_in(pins[1]), .block_input_three_in(pins[2]),
        .route_src_in, .phase_l1_in, .phase_l2_in, .phase_l3_in, .residual_current_in, .stage_block_out,
        .start_output_out, .trip_output_out, .active_bank_out, .reset_indicators_out, .reset_latches_out,
        .reset_registers_out, .disp_value_out, .disp_lamp_out, .irq_out);
    always #5 clk_in = ~clk_in;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // ==========================================================
    // Bus master: single word transfers, waits on hready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        haddr_in <= {24'h00_0000, a};
        hwrite_in <= wr;
        htrans_in <= 2'h2;
        @(posedge clk_in);
        while (hready_in !== 1'b1) @(posedge clk_in);
        htrans_in <= 2'h0;
        hwdata_in <= d;
        @(posedge clk_in);
        while (hready_in !== 1'b1) @(posedge clk_in);
        q = hrdata_out;
    endtask
    task automatic csum(input logic [31:0] sel);
        bus(1, OFS_CSUM_SEL, sel);
        bus(0, OFS_CSUM, 0);
    endtask
    // Margin over the four-edge pin path, then off the edge
    task automatic wt();
        repeat (5) @(posedge clk_in);
        #1;
    endtask
    function automatic logic [13:0] disp_exp(input int s);
        int a, b, c, t, mx, mn;
        a = phase_l1_in;
        b = phase_l2_in;
        c = phase_l3_in;
        t = s == 0 ? a : (s == 1 ? b : c);
        mx = a > b ? (a > c ? a : c) : (b > c ? b : c);
        mn = a < b ? (a < c ? a : c) : (b < c ? b : c);
        if (s < 3) return {4'(1 << s), 10'(t > PHASE_MAX ? PHASE_MAX : t)};
        if (s == 3) return {4'h8, residual_current_in > RESID_MAX ? RESID_MAX : residual_current_in};
        return {4'h8, 10'(mx ? (mx - mn) * 100 / mx : 0)};
    endfunction
    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        stop_test();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1;
        bus(1, OFS_CTRL_GRP, 32'hffff_ff2f);
        csum(0);
        chk("csum ctrl1", q, 32'h2f);
        lvl <= 3'h1;
        wt();
        chk("block", stage_block_out, 32'h1f);
        bus(0, OFS_STATUS, 0);
        chk("status block", q[12:8], 32'h1f);
        lvl <= 3'h0;
        wt();
        chk("unblock", stage_block_out, 32'h0);
        bus(1, OFS_CTRL, 1);
        wt();
        chk("bank serial", active_bank_out, 1);
        bus(1, 8'h08, 32'h10);
        wt();
        chk("bank pin low", active_bank_out, 0);
        lvl <= 3'h2;
        wt();
        chk("bank pin high", active_bank_out, 1);
        bus(1, 8'h08, 0);
        bus(1, OFS_CTRL, 0);
        wt();
        chk("bank ignored", active_bank_out, 0);
        lvl <= 3'h0;
        for (int k = 5; k < 8; k++) begin
            bus(1, 8'h0c, 32'h1 << k);
            csum(2);
            chk("csum ctrl3", q, 32'h1 << k);
            lvl <= 3'h4;
            wt();
            chk("resets", {reset_indicators_out, reset_latches_out, reset_registers_out}, (32'h7 << (7 - k)) & 32'h7);
            lvl <= 3'h0;
            wt();
        end
        bus(1, OFS_IRQ_STAT, 32'hf);
        bus(1, OFS_IRQ_MASK, 32'h4);
        for (int g = 0; g < NUM_ROUTE_GROUPS; g++) begin
            v = 8'($random(seed)) | (g == 0 ? 8'h10 : 8'h00);
            bus(1, 8'(8'h10 + 4 * g), {24'h00_0000, v});
            route_src_in <= 11'h1 << g;
            csum(g + 3);
            chk("csum route", q, v);
            chk("route", {trip_output_out, start_output_out}, v);
        end
        chk("irq set", irq_out, 1);
        route_src_in <= 0;
        bus(1, OFS_IRQ_STAT, 32'h4);
        wt();
        chk("irq clear", irq_out, 0);
        for (int p = 0; p < 2; p++) begin
            phase_l1_in <= p ? 10'({$random(seed)} % 600) : 10'h3ff;
            phase_l2_in <= 10'({$random(seed)} % 600);
            phase_l3_in <= 10'({$random(seed)} % 600);
            residual_current_in <= p ? 10'({$random(seed)} % 200) : 10'h3ff;
            for (int s = 0; s < (p ? 5 : 4); s++) begin
                bus(1, OFS_DISP_SEL, s);
                wt();
                chk("display", {disp_lamp_out, disp_value_out}, disp_exp(s));
                bus(0, OFS_DISP_VAL, 0);
                chk("display reg", q, disp_exp(s));
            end
        end
        bus(0, 8'h80, 0);
        chk("unmapped", q, 0);
        chk("okay", hresp_out, 0);
        stop_test();
    end
endmodule
`default_nettype wire
